// *** mlc_pkg.sv ***
// Shared constants and types for module low-speed control, both ends.
// Assumes a single 20 MHz pclk shared by module and host logic.
`default_nettype none
package mlc_pkg;
    // Clock period in ns
    localparam int CLK_PERIOD_NS = 50;
    // Least reset pulse length in ns, and in cycles (rounded up)
    localparam int RESET_MIN_NS = 1000;
    localparam int RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Management interface start-up time in cycles
    localparam int INIT_CYC = 16;
    // Host reset pulse it drives, in cycles
    localparam int HOST_RESET_CYC = RESET_MIN_CYC + 4;
    // Default setting value after a complete reset
    localparam logic [7:0] SETTING_RESET = 8'h00;
    // Host APB register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN = 8'h10;
    // Control bit positions
    localparam int CTRL_SELECT = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_INIT_SW = 2;
    localparam int CTRL_HIGH_POWER = 3;
    // Interrupt event bit positions
    localparam int IRQ_MODULE_INT = 0;
    localparam int IRQ_RESET_DONE = 1;
    localparam int IRQ_PRESENT_CHG = 2;
    localparam int IRQ_W = 3;
    // Module power states
    typedef enum logic [1:0] {
        PWR_RESET, PWR_INIT, PWR_LOW, PWR_HIGH
    } mlc_pwr_type;
endpackage : mlc_pkg
`default_nettype wire

// *** mlc_if.sv ***
// Low-speed pin bundle between the module and the host controller.
// Open-drain pins resolve here from output enables (low = driving).
`default_nettype none
interface mlc_if;
    logic module_select_n;
    logic module_reset_n;
    logic init_control_select;
    logic high_power_enable; // Stands for the software power request
    logic fault_event; // Module-side critical condition
    logic present_oe_n;
    logic interrupt_oe_n;
    logic module_present_n;
    logic interrupt_n;
    // Pull-ups on the host board; only low is ever driven
    assign module_present_n = present_oe_n;
    assign interrupt_n = interrupt_oe_n;
    modport device (
        input module_select_n, module_reset_n, init_control_select,
        input high_power_enable,
        output present_oe_n, interrupt_oe_n
    );
    modport host (
        output module_select_n, module_reset_n, init_control_select,
        output high_power_enable,
        input module_present_n, interrupt_n
    );
endinterface : mlc_if
`default_nettype wire

// *** mlc_device.sv ***
// Module-side low-speed control: select, reset, init mode, interrupt.
// Assumes pins synchronous to pclk; management traffic enters as strobes.
//
// What this block does
// - Answer management only while selected low
// - Host gives each module its own select
// - Long reset pulse restores all default settings
// - Host ignores status until reset completes
// - Reset done: interrupt low, pending flag cleared
// - Power-up raises completion interrupt unprompted
// - Software mode stays low power until enabled
// - Hardware mode goes high power after init
// - Host holds init mode fixed while present
// - Present pin pulled to ground when inserted
// - Interrupt low on fault or critical status
// - Host reads memory map to find source
`default_nettype none
module mlc_device #(
    parameter int RESET_MIN = mlc_pkg::RESET_MIN_CYC,
    parameter int INIT_TIME = mlc_pkg::INIT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to host
    mlc_if.device lnk,
    // Management access strobes from the two-wire engine
    input wire logic mgmt_req,
    input wire logic mgmt_write,
    input wire logic [7:0] mgmt_wdata,
    input wire logic mgmt_ack_int, // Host read clears interrupt
    input wire logic fault_in,
    // Status
    output logic mgmt_resp,
    output logic [7:0] setting,
    output logic status_pending_flag,
    output logic high_power,
    output logic low_power_select
);
    localparam int CW = $clog2(RESET_MIN + INIT_TIME + 2);
    mlc_pkg::mlc_pwr_type st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [7:0] set_q, set_d;
    logic pend_q, pend_d;
    logic int_q, int_d;
    logic resp_q, resp_d;
    logic long_rst;

    assign long_rst = !lnk.module_reset_n && cnt_q >= CW'(RESET_MIN);

    // Next-state for power, settings and interrupt
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        set_d = set_q;
        pend_d = pend_q;
        int_d = int_q;
        resp_d = 1'b0;
        // Short low pulses are glitches and count back from zero
        if (!lnk.module_reset_n) begin
            if (cnt_q < CW'(RESET_MIN)) begin
                cnt_d = cnt_q + CW'(1);
            end
        end
        unique case (st_q)
            mlc_pkg::PWR_RESET: begin
                set_d = mlc_pkg::SETTING_RESET;
                pend_d = 1'b1;
                int_d = 1'b0;
                if (lnk.module_reset_n) begin
                    st_d = mlc_pkg::PWR_INIT;
                    cnt_d = '0;
                end
            end
            mlc_pkg::PWR_INIT: begin
                cnt_d = cnt_q + CW'(1);
                if (cnt_q >= CW'(INIT_TIME)) begin
                    pend_d = 1'b0;
                    int_d = 1'b1;
                    cnt_d = '0;
                    st_d = mlc_pkg::PWR_LOW;
                end
            end
            mlc_pkg::PWR_LOW: begin
                // hardware mode goes up; software waits
                if (!lnk.init_control_select || lnk.high_power_enable) begin
                    st_d = mlc_pkg::PWR_HIGH;
                end
            end
            mlc_pkg::PWR_HIGH: begin
                // software may return to low power
                if (lnk.init_control_select && !lnk.high_power_enable) begin
                    st_d = mlc_pkg::PWR_LOW;
                end
            end
        endcase
        if (lnk.module_reset_n && st_q != mlc_pkg::PWR_INIT) begin
            cnt_d = '0;
        end
        if (mgmt_req && !lnk.module_select_n &&
            st_q != mlc_pkg::PWR_RESET) begin
            resp_d = 1'b1;
            if (mgmt_write) begin
                set_d = mgmt_wdata;
            end
            if (mgmt_ack_int) begin
                int_d = 1'b0;
            end
        end
        if (fault_in && st_q != mlc_pkg::PWR_RESET) begin
            int_d = 1'b1;
        end
        if (long_rst) begin
            st_d = mlc_pkg::PWR_RESET;
        end
    end

    // State registers; reset enters PWR_RESET so power-up posts completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= mlc_pkg::PWR_RESET;
            cnt_q <= '0;
            set_q <= mlc_pkg::SETTING_RESET;
            pend_q <= 1'b1;
            int_q <= 1'b0;
            resp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            set_q <= set_d;
            pend_q <= pend_d;
            int_q <= int_d;
            resp_q <= resp_d;
        end
    end

    // Output flops
    logic hp_q, lp_q, pres_q, ioe_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hp_q <= 1'b0;
            lp_q <= 1'b1;
            pres_q <= 1'b1;
            ioe_q <= 1'b1;
        end else begin
            hp_q <= (st_d == mlc_pkg::PWR_HIGH);
            // Own flop so the pin never glitches through an inverter
            lp_q <= (st_d != mlc_pkg::PWR_HIGH);
            pres_q <= 1'b0;
            // enable low only to pull low
            ioe_q <= !int_d;
        end
    end

    assign lnk.present_oe_n = pres_q;
    assign lnk.interrupt_oe_n = ioe_q;
    assign mgmt_resp = resp_q;
    assign setting = set_q;
    assign status_pending_flag = pend_q;
    assign high_power = hp_q;
    assign low_power_select = lp_q;
endmodule : mlc_device
`default_nettype wire

// *** mlc_host.sv ***
// Host-side controller: drives select, reset, init mode over the link.
// Software reaches it over APB; registers are word aligned.
`default_nettype none
module mlc_host #(
    parameter int RESET_LEN = mlc_pkg::HOST_RESET_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to module
    mlc_if.host lnk,
    // Interrupt
    output logic irq
);
    localparam int IW = mlc_pkg::IRQ_W;
    localparam int RW = $clog2(RESET_LEN + 2);
    logic [3:0] ctrl_q, ctrl_d;
    logic [IW-1:0] stat_q, stat_d, en_q, en_d, ev;
    logic [RW-1:0] rcnt_q, rcnt_d;
    logic rst_busy;
    logic int_q, pres_q, irq_q;
    logic [31:0] rd_q, rd_d;
    logic err_q, err_d, rdy_q, rdy_d;
    logic wr, rd;
    logic wait_q, wait_d;
    logic rstn_q;
    logic int_fall;

    assign wr = psel && penable && pwrite && rdy_q;
    assign rd = psel && !penable;
    assign rst_busy = rcnt_q != '0;

    // Falling edge only; a held-low line must not re-post events
    assign int_fall = int_q && !lnk.interrupt_n;

    // Events: first fall after a reset is completion, later ones faults
    always_comb begin
        ev = '0;
        ev[mlc_pkg::IRQ_MODULE_INT] = int_fall && !wait_q;
        ev[mlc_pkg::IRQ_RESET_DONE] = int_fall && wait_q && !rst_busy;
        ev[mlc_pkg::IRQ_PRESENT_CHG] = pres_q != lnk.module_present_n;
    end

    // Register next values; APB answers one cycle after setup
    always_comb begin
        ctrl_d = ctrl_q;
        en_d = en_q;
        stat_d = stat_q;
        rcnt_d = rst_busy ? rcnt_q - RW'(1) : rcnt_q;
        rd_d = rd_q;
        err_d = 1'b0;
        rdy_d = rd;
        wait_d = wait_q;
        // completion awaited until the interrupt falls
        if (int_fall && !rst_busy) begin
            wait_d = 1'b0;
        end
        if (wr) begin
            unique case (paddr)
                mlc_pkg::REG_CTRL: begin
                    ctrl_d = pwdata[3:0];
                    if (!lnk.module_present_n) begin
                        ctrl_d[mlc_pkg::CTRL_INIT_SW] =
                            ctrl_q[mlc_pkg::CTRL_INIT_SW];
                    end
                    if (pwdata[mlc_pkg::CTRL_RESET]) begin
                        rcnt_d = RW'(RESET_LEN);
                        wait_d = 1'b1;
                    end
                    ctrl_d[mlc_pkg::CTRL_RESET] = 1'b0;
                end
                mlc_pkg::REG_IRQ_CLR: stat_d = stat_q & ~pwdata[IW-1:0];
                mlc_pkg::REG_IRQ_EN: en_d = pwdata[IW-1:0];
                default: ;
            endcase
        end
        // Set wins over clear
        stat_d = stat_d | ev;
        if (rd) begin
            err_d = 1'b0;
            unique case (paddr)
                mlc_pkg::REG_CTRL: rd_d = {28'h0, ctrl_q};
                mlc_pkg::REG_STATUS: rd_d = {29'h0, rst_busy,
                    !lnk.interrupt_n, !lnk.module_present_n};
                mlc_pkg::REG_IRQ_STAT: rd_d = {29'h0, stat_q};
                mlc_pkg::REG_IRQ_EN: rd_d = {29'h0, en_q};
                mlc_pkg::REG_IRQ_CLR: rd_d = 32'h0;
                default: begin
                    rd_d = 32'h0;
                    err_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 4'h0;
            en_q <= '0;
            stat_q <= '0;
            rcnt_q <= '0;
            rd_q <= 32'h0;
            err_q <= 1'b0;
            rdy_q <= 1'b0;
            int_q <= 1'b1;
            pres_q <= 1'b1;
            irq_q <= 1'b0;
            wait_q <= 1'b1;
            rstn_q <= 1'b1;
        end else begin
            wait_q <= wait_d;
            rstn_q <= (rcnt_d == '0);
            ctrl_q <= ctrl_d;
            en_q <= en_d;
            stat_q <= stat_d;
            rcnt_q <= rcnt_d;
            rd_q <= rd_d;
            err_q <= err_d;
            rdy_q <= rdy_d;
            int_q <= lnk.interrupt_n;
            pres_q <= lnk.module_present_n;
            irq_q <= |(stat_d & en_d);
        end
    end

    // one select line per module; pulse outlasts minimum
    assign lnk.module_select_n = !ctrl_q[mlc_pkg::CTRL_SELECT];
    assign lnk.module_reset_n = rstn_q;
    assign lnk.init_control_select = ctrl_q[mlc_pkg::CTRL_INIT_SW];
    assign lnk.high_power_enable = ctrl_q[mlc_pkg::CTRL_HIGH_POWER];
    assign prdata = rd_q;
    assign pready = rdy_q;
    assign pslverr = err_q && rdy_q;
    assign irq = irq_q;
endmodule : mlc_host
`default_nettype wire

// *** mlc_chk.sv ***
// Concurrent checks on the link pins between module and host ends.
// Assumes one pclk domain; link pins arrive as plain inputs.
`default_nettype none
module mlc_chk #(
    parameter int RESET_MIN = mlc_pkg::RESET_MIN_CYC,
    parameter int INIT_TIME = mlc_pkg::INIT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link pins
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic init_control_select,
    input wire logic module_present_n,
    input wire logic interrupt_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DONE_HI = INIT_TIME + 2;
    localparam int UP_CHK = INIT_TIME + 3;
    localparam int RST_CHK = RESET_MIN;
    logic [7:0] low_q;
    logic [7:0] low_d;
    logic [7:0] up_q;
    logic [7:0] up_d;
    // Saturating counts: reset-low run and cycles since power-up
    always_comb begin
        low_d = module_reset_n ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
        up_d = up_q + {7'h00, up_q != 8'hff};
    end
    // Count registers; cleared with the bench reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 8'h00;
            up_q <= 8'h00;
        end else begin
            low_q <= low_d;
            up_q <= up_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_present_low: assert property ($past(presetn) |-> !module_present_n)
        else $error("present pin not held low");
    a_done_int: assert property ($rose(module_reset_n)
        && low_q >= RESET_MIN |-> ##[1:DONE_HI] !interrupt_n)
        else $error("no completion interrupt after reset");
    a_done_late: assert property ($rose(module_reset_n)
        && low_q >= RESET_MIN |-> interrupt_n [*3])
        else $error("completion posted before init ended");
    a_reset_quiet: assert property (!module_reset_n
        && low_q >= RESET_MIN + 2 |-> interrupt_n)
        else $error("interrupt low during qualified reset");
    a_int_holds: assert property (!interrupt_n && module_select_n
        && module_reset_n |=> !interrupt_n)
        else $error("interrupt cleared while not selected");
    a_init_fixed: assert property (!module_present_n
        && !$past(module_present_n) |-> $stable(init_control_select))
        else $error("init mode changed while present");
    a_host_pulse: assert property ($fell(module_reset_n)
        |-> ##RST_CHK !module_reset_n)
        else $error("host reset pulse too short");
    a_power_up: assert property (up_q == UP_CHK && module_reset_n
        |-> !interrupt_n)
        else $error("no completion interrupt after power-up");
    // Main scenarios reached
    c_reset_done: cover property ($rose(module_reset_n) && low_q >= RESET_MIN);
    c_int_clear: cover property ($rose(interrupt_n) && !module_select_n);
    c_present: cover property ($fell(module_present_n));
endmodule : mlc_chk
`default_nettype wire

// *** module_lowspeed_control_tb.sv ***
// Self-checking bench: host and module ends joined by the link.
// Assumes 20 MHz pclk; reset and init counts shortened to 4 cycles.
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module module_lowspeed_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RMIN = 4;
    localparam int ITIME = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, mgmt_resp, status_pending_flag;
    logic high_power, low_power_select;
    logic mgmt_req = 1'b0;
    logic mgmt_write = 1'b1;
    logic mgmt_ack_int = 1'b0;
    logic fault_in = 1'b0;
    logic [7:0] mgmt_wdata = 8'h00;
    logic [7:0] setting;
    int err_total = 0;
    int num_checks = 0;
    mlc_if lnk_i ();
    mlc_device #(.RESET_MIN(RMIN), .INIT_TIME(ITIME)) mlc_device_i (
        .pclk(pclk), .presetn(presetn), .lnk(lnk_i.device),
        .mgmt_req(mgmt_req), .mgmt_write(mgmt_write),
        .mgmt_wdata(mgmt_wdata), .mgmt_ack_int(mgmt_ack_int),
        .fault_in(fault_in), .mgmt_resp(mgmt_resp), .setting(setting),
        .status_pending_flag(status_pending_flag), .high_power(high_power),
        .low_power_select(low_power_select));
    mlc_host #(.RESET_LEN(RMIN + 4)) mlc_host_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lnk(lnk_i.host), .irq(irq));
    mlc_chk #(.RESET_MIN(RMIN), .INIT_TIME(ITIME)) mlc_chk_i (
        .pclk(pclk), .presetn(presetn),
        .module_select_n(lnk_i.module_select_n),
        .module_reset_n(lnk_i.module_reset_n),
        .init_control_select(lnk_i.init_control_select),
        .module_present_n(lnk_i.module_present_n),
        .interrupt_n(lnk_i.interrupt_n));
    // Free-running 50 ns clock
    always #25 pclk = ~pclk;
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        // A slave that never answers counts as a mismatch
        if (!pready) begin
            err_total++;
            $display("[FAIL] apb no pready at %0h", a);
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // One management strobe; reports whether the module answered
    task automatic mgmt(input logic [7:0] d, output logic seen);
        @(posedge pclk);
        {mgmt_req, mgmt_wdata, mgmt_ack_int} <= {1'b1, d, 1'b1};
        @(posedge pclk);
        {mgmt_req, mgmt_ack_int} <= 2'b00;
        seen = 1'b0;
        repeat (4) begin
            @(posedge pclk);
            seen = seen | mgmt_resp;
        end
    endtask : mgmt
    task automatic t_power_up;
        logic [31:0] r;
        logic e;
        cyc(ITIME + 6);
        `CHK("present_n", 1'b0, lnk_i.module_present_n)
        `CHK("interrupt_n", 1'b0, lnk_i.interrupt_n)
        `CHK("pending", 1'b0, status_pending_flag)
        `CHK("high_power", 1'b1, high_power)
        `CHK("low_power_select", 1'b0, low_power_select)
        apb(1'b0, mlc_pkg::REG_IRQ_STAT, 32'h0, r, e);
        `CHK("done_event", 1'b1, r[mlc_pkg::IRQ_RESET_DONE])
        `CHK("no_fault_event", 1'b0, r[mlc_pkg::IRQ_MODULE_INT])
        apb(1'b0, mlc_pkg::REG_STATUS, 32'h0, r, e);
        `CHK("status_word", 32'h3, r)
        `CHK("status_err", 1'b0, e)
        $display("t_power_up done");
    endtask : t_power_up
    // Mask, enable, clear, then an unmapped read
    task automatic t_irq;
        logic [31:0] r;
        logic e;
        apb(1'b1, mlc_pkg::REG_IRQ_EN, 32'h0, r, e);
        cyc(2);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, mlc_pkg::REG_IRQ_EN, 32'h2, r, e);
        cyc(2);
        `CHK("irq_on", 1'b1, irq)
        apb(1'b1, mlc_pkg::REG_IRQ_CLR, 32'h2, r, e);
        cyc(2);
        `CHK("irq_cleared", 1'b0, irq)
        apb(1'b0, 8'h40, 32'h0, r, e);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, r)
        $display("t_irq done");
    endtask : t_irq
    task automatic t_select;
        logic [31:0] r;
        logic e;
        logic seen;
        mgmt(8'h5a, seen);
        `CHK("resp_unselected", 1'b0, seen)
        `CHK("int_kept", 1'b0, lnk_i.interrupt_n)
        apb(1'b1, mlc_pkg::REG_CTRL, 32'h1, r, e);
        cyc(1);
        `CHK("select_n", 1'b0, lnk_i.module_select_n)
        mgmt(8'h5a, seen);
        `CHK("resp_selected", 1'b1, seen)
        `CHK("setting", 8'h5a, setting)
        `CHK("int_released", 1'b1, lnk_i.interrupt_n)
        $display("t_select done");
    endtask : t_select
    task automatic t_fault;
        logic [31:0] r;
        logic e;
        logic seen;
        @(posedge pclk);
        fault_in <= 1'b1;
        @(posedge pclk);
        fault_in <= 1'b0;
        cyc(3);
        `CHK("fault_int", 1'b0, lnk_i.interrupt_n)
        apb(1'b0, mlc_pkg::REG_IRQ_STAT, 32'h0, r, e);
        `CHK("fault_event", 1'b1, r[mlc_pkg::IRQ_MODULE_INT])
        mgmt(8'h33, seen);
        `CHK("fault_cleared", 1'b1, lnk_i.interrupt_n)
        $display("t_fault done");
    endtask : t_fault
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        int n;
        apb(1'b1, mlc_pkg::REG_CTRL, 32'hf, r, e);
        cyc(RMIN + 3);
        `CHK("reset_n", 1'b0, lnk_i.module_reset_n)
        `CHK("pending_busy", 1'b1, status_pending_flag)
        `CHK("power_in_reset", 1'b0, high_power)
        `CHK("init_select", 1'b0, lnk_i.init_control_select)
        n = 0;
        while (lnk_i.interrupt_n && n < 40) begin
            @(posedge pclk);
            n++;
        end
        cyc(1);
        `CHK("done_int", 1'b0, lnk_i.interrupt_n)
        `CHK("pending_done", 1'b0, status_pending_flag)
        `CHK("setting_default", 8'h00, setting)
        `CHK("power_after", 1'b1, high_power)
        $display("t_reset done");
    endtask : t_reset
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // Main sequence after a 20-cycle reset
    initial begin
        cyc(20);
        presetn <= 1'b1;
        t_power_up();
        t_irq();
        t_select();
        t_fault();
        t_reset();
        end_of_test();
    end
    // Watchdog: tests need well under 1000 cycles
    initial begin
        #500000;
        err_total++;
        end_of_test();
    end
endmodule : module_lowspeed_control_tb
`undef CHK
`default_nettype wire
